// ---- include/pcirs_pkg.sv ----
// constants and types shared by the receive status reporting block
package pcirs_pkg;
	// ----------------------------------------------------------------
	// receive status codes
	// ----------------------------------------------------------------
	localparam logic [2:0] ST_OK = 3'h0;
	localparam logic [2:0] ST_SKP_ADD = 3'h1;
	localparam logic [2:0] ST_SKP_REM = 3'h2;
	localparam logic [2:0] ST_RX_DET = 3'h3;
	localparam logic [2:0] ST_DEC_ERR = 3'h4;
	localparam logic [2:0] ST_OVF = 3'h5;
	localparam logic [2:0] ST_UDF = 3'h6;
	localparam logic [2:0] ST_DISP_ERR = 3'h7;

	// ----------------------------------------------------------------
	// symbols and elastic buffer entry layout
	// ----------------------------------------------------------------
	localparam logic [7:0] EDB_BYTE = 8'hFE;
	localparam int SYM_W = 8;
	localparam int ENT_K = 8;
	localparam int ENT_DEC = 9;
	localparam int ENT_DISP = 10;
	localparam int ENT_ADD = 11;
	localparam int ENT_REM = 12;
	localparam int ENT_OVF = 13;
	localparam int ENTRY_W = 14;
	localparam int RAW_W = 10;
	localparam int EB_DEPTH_DEF = 8;
	localparam int EB_DEPTH_MIN = 7;

	// ----------------------------------------------------------------
	// timing: one symbol per clock at 100 MHz
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int INV_MAX_SYMBOLS = 20;
	localparam int SYMBOLS_PER_CLK = 1;
	localparam int INV_MAX_CYC = INV_MAX_SYMBOLS / SYMBOLS_PER_CLK;
	localparam int SYNC_STAGES = 2;
	localparam int INV_LATENCY_CYC = SYNC_STAGES + 1;

	// receiver detect sequencing
	typedef enum logic [1:0] {
		DET_IDLE = 2'b00,
		DET_SHOW = 2'b01,
		DET_DONE = 2'b10
	} pcirs_det_t;
endpackage : pcirs_pkg

// ---- rtl/pcirs_elastic_buf.sv ----
// elastic buffer storage for received symbols with their flags
`timescale 1ns/100ps
module pcirs_elastic_buf #(
	parameter int WIDTH = pcirs_pkg::ENTRY_W,
	parameter int DEPTH = pcirs_pkg::EB_DEPTH_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// write side
	input wire logic wrEn,
	input wire logic [WIDTH-1:0] wrWord,
	// read side
	input wire logic rdEn,
	output logic [WIDTH-1:0] rdWord,
	// fill state
	output logic empty,
	output logic full,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

	// ----------------------------------------------------------------
	// storage and pointers
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wrPtr_ff;
	logic [AW-1:0] rdPtr_ff;
	logic [AW:0] count_ff;
	logic doWr;
	logic doRd;

	// a shallower buffer cannot absorb the worst-case drift between skip sets
	if (DEPTH < pcirs_pkg::EB_DEPTH_MIN) begin : g_depth_bad
		$error("elastic buffer depth below seven symbols");
	end

	// a write into a full buffer is only legal when a read frees a slot
	assign doWr = wrEn && (!full || rdEn);
	assign doRd = rdEn && !empty;
	assign empty = (count_ff == '0);
	assign full = (count_ff == DEPTH_C);
	assign level = count_ff;
	assign rdWord = mem_ff[rdPtr_ff];

	// storage array holds no control state, so no reset
	always_ff @(posedge clk) begin
		if (doWr) begin
			mem_ff[wrPtr_ff] <= wrWord;
		end
	end

	// pointers wrap at depth, which need not be a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (doWr) begin
				wrPtr_ff <= (wrPtr_ff == LAST_C) ? '0 : wrPtr_ff + 1'b1;
			end
			if (doRd) begin
				rdPtr_ff <= (rdPtr_ff == LAST_C) ? '0 : rdPtr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
		end
	end

	chk_level_bound: assert property (@(posedge clk) disable iff (!rst_n) count_ff <= DEPTH_C) // [RULE_12]
		else $error("elastic buffer level above depth");
endmodule : pcirs_elastic_buf

// ---- rtl/pcirs_status_top.sv ----
// receive status reporting, polarity inversion and tx disparity control
// Behaviour
// [RULE_01] status codes: ok, skp added, skp removed, detected, decode, overflow, underflow, disparity
// [RULE_02] each receive error shows for one cycle, aligned with its byte
// [RULE_03] several errors on one byte: decode, overflow, underflow, disparity in that order
// [RULE_04] decode error replaces the byte with EDB and shows decode code
// [RULE_05] disparity error shows code while the byte itself passes through
// [RULE_06] underflow inserts EDB and shows underflow code with it
// [RULE_07] overflow drops a symbol and reports in its would-be slot
// [RULE_08] received data inverted while inversion requested, within 20 symbols
// [RULE_09] one-cycle disparity pulse makes its aligned byte go out with negative disparity
// [RULE_10] skp added or removed is shown for one cycle with the COM symbol
// [RULE_11] after receiver detect, show detected or ok before signalling completion; the code shows it in the same cycle that phyStatus rises
// [RULE_12] elastic buffer holds at least seven symbols
// [RULE_13] cycles with nothing to report show the data-ok code
`timescale 1ns/100ps
module pcirs_status_top #(
	parameter int EB_DEPTH = pcirs_pkg::EB_DEPTH_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// mac control pins
	input wire logic rx_invert_request,
	input wire logic rx_detect_or_loopback_request,
	input wire logic tx_force_negative_disparity,
	input wire logic [7:0] txDataIn,
	input wire logic txKIn,
	// transmit toward encoder
	output logic [7:0] txDataOut,
	output logic txKOut,
	output logic txForceNeg,
	// raw receive symbols around the decoder
	input wire logic [9:0] rawSymIn,
	output logic [9:0] rawSymOut,
	output logic rxInvertActive,
	// decoded receive symbols
	input wire logic symValid,
	input wire logic [7:0] symData,
	input wire logic symK,
	input wire logic symDecErr,
	input wire logic symDispErr,
	input wire logic symSkpAdded,
	input wire logic symSkpRemoved,
	// receiver detect analog side
	input wire logic detDone,
	input wire logic farEndPresent,
	// parallel receive toward mac
	output logic [7:0] rxData,
	output logic rxK,
	output logic rxValid,
	output logic [2:0] rx_status_code,
	output logic phyStatus
);
	localparam int LW = $clog2(EB_DEPTH) + 1;
	localparam logic [LW-1:0] PRIME_C = LW'(EB_DEPTH / 2);

	// the synchroniser must leave the inversion inside its symbol budget
	if (pcirs_pkg::INV_LATENCY_CYC > pcirs_pkg::INV_MAX_CYC) begin : g_inv_budget
		$error("inversion latency exceeds limit");
	end

	// ----------------------------------------------------------------
	// status selection by fixed priority
	// ----------------------------------------------------------------
	function automatic logic [2:0] pickStatus(input logic [pcirs_pkg::ENTRY_W-1:0] w, input logic udf); // [RULE_01]
		logic [2:0] code;
		code = pcirs_pkg::ST_OK; // [RULE_13]
		if (w[pcirs_pkg::ENT_DEC]) begin
			code = pcirs_pkg::ST_DEC_ERR; // [RULE_03]
		end else if (w[pcirs_pkg::ENT_OVF]) begin
			code = pcirs_pkg::ST_OVF;
		end else if (udf) begin
			code = pcirs_pkg::ST_UDF;
		end else if (w[pcirs_pkg::ENT_DISP]) begin
			code = pcirs_pkg::ST_DISP_ERR; // [RULE_05]
		end else if (w[pcirs_pkg::ENT_ADD]) begin
			code = pcirs_pkg::ST_SKP_ADD; // [RULE_10]
		end else if (w[pcirs_pkg::ENT_REM]) begin
			code = pcirs_pkg::ST_SKP_REM;
		end
		return code;
	endfunction : pickStatus

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int MW = 12;
	logic [MW-1:0] macSync1_ff;
	logic [MW-1:0] macSync2_ff;

	// data travels with its control bit so alignment survives the sync
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			macSync1_ff <= '0;
			macSync2_ff <= '0;
		end else begin
			macSync1_ff <= {rx_invert_request, rx_detect_or_loopback_request,
				tx_force_negative_disparity, txKIn, txDataIn};
			macSync2_ff <= macSync1_ff;
		end
	end

	logic invReq;
	logic detReq;
	assign invReq = macSync2_ff[11];
	assign detReq = macSync2_ff[10];
	assign txForceNeg = macSync2_ff[9]; // [RULE_09]
	assign txKOut = macSync2_ff[8];
	assign txDataOut = macSync2_ff[7:0];

	// ----------------------------------------------------------------
	// polarity inversion of raw symbols
	// ----------------------------------------------------------------
	logic invActive_ff;
	logic [9:0] rawSym_ff;

	// three cycles from pin to rxInvertActive and four to inverted rawSymOut, well inside twenty symbols
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			invActive_ff <= 1'b0;
			rawSym_ff <= '0;
		end else begin
			invActive_ff <= invReq; // [RULE_08]
			rawSym_ff <= invActive_ff ? ~rawSymIn : rawSymIn; // [RULE_08]
		end
	end
	assign rxInvertActive = invActive_ff;
	assign rawSymOut = rawSym_ff;

	// ----------------------------------------------------------------
	// elastic buffer and overflow bookkeeping
	// ----------------------------------------------------------------
	logic [pcirs_pkg::ENTRY_W-1:0] wrWord;
	logic [pcirs_pkg::ENTRY_W-1:0] rdWord;
	logic ebEmpty;
	logic ebFull;
	logic [LW-1:0] ebLevel;
	logic primed_ff;
	logic pendOvf_ff;
	logic rdEn;
	logic drop;
	logic wrEn;
	pcirs_pkg::pcirs_det_t detState_ff;

	// reads pause while detect owns the status bus, so no symbol vanishes unreported
	assign rdEn = primed_ff && !ebEmpty && (detState_ff == pcirs_pkg::DET_IDLE); // [RULE_07]
	assign drop = symValid && ebFull && !rdEn; // [RULE_07]
	assign wrEn = symValid && !drop;
	assign wrWord = {pendOvf_ff, symSkpRemoved, symSkpAdded, symDispErr, symDecErr, symK, symData};

	pcirs_elastic_buf #(
		.WIDTH(pcirs_pkg::ENTRY_W),
		.DEPTH(EB_DEPTH)
	) u_ebuf (
		.clk(clk),
		.rst_n(rst_n),
		.wrEn(wrEn),
		.wrWord(wrWord),
		.rdEn(rdEn),
		.rdWord(rdWord),
		.empty(ebEmpty),
		.full(ebFull),
		.level(ebLevel)
	);

	// the slot of a dropped symbol rides on the next stored symbol; a new drop wins over the clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pendOvf_ff <= 1'b0;
		end else if (drop) begin
			pendOvf_ff <= 1'b1; // [RULE_07]
		end else if (wrEn) begin
			pendOvf_ff <= 1'b0;
		end
	end

	// reading starts at half fill so both drift directions have margin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			primed_ff <= 1'b0;
		end else if (ebLevel >= PRIME_C) begin
			primed_ff <= 1'b1; // [RULE_12]
		end
	end

	// ----------------------------------------------------------------
	// receiver detect sequencing
	// ----------------------------------------------------------------
	logic farPresent_ff;

	// result goes on the status bus in the same cycle that completion is flagged
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			detState_ff <= pcirs_pkg::DET_IDLE;
			farPresent_ff <= 1'b0;
		end else begin
			case (detState_ff)
				pcirs_pkg::DET_IDLE: begin
					if (detReq && detDone) begin
						farPresent_ff <= farEndPresent;
						detState_ff <= pcirs_pkg::DET_SHOW; // [RULE_11]
					end
				end
				pcirs_pkg::DET_SHOW: begin
					detState_ff <= pcirs_pkg::DET_DONE; // [RULE_11]
				end
				pcirs_pkg::DET_DONE: begin
					if (!detReq) begin
						detState_ff <= pcirs_pkg::DET_IDLE;
					end
				end
				default: begin
					detState_ff <= pcirs_pkg::DET_IDLE;
				end
			endcase
		end
	end
	assign phyStatus = (detState_ff == pcirs_pkg::DET_DONE);

	// ----------------------------------------------------------------
	// parallel receive output and status
	// ----------------------------------------------------------------
	logic [7:0] rxData_ff;
	logic rxK_ff;
	logic rxValid_ff;
	logic [2:0] status_ff;

	// one code per output slot, so every error lasts exactly one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rxData_ff <= '0;
			rxK_ff <= 1'b0;
			rxValid_ff <= 1'b0;
			status_ff <= pcirs_pkg::ST_OK;
		end else if (detState_ff != pcirs_pkg::DET_IDLE) begin
			rxValid_ff <= 1'b0;
			status_ff <= farPresent_ff ? pcirs_pkg::ST_RX_DET : pcirs_pkg::ST_OK; // [RULE_11]
		end else if (primed_ff && ebEmpty) begin
			rxData_ff <= pcirs_pkg::EDB_BYTE; // [RULE_06]
			rxK_ff <= 1'b1;
			rxValid_ff <= 1'b1;
			status_ff <= pcirs_pkg::ST_UDF; // [RULE_06]
		end else if (rdEn) begin
			rxData_ff <= rdWord[pcirs_pkg::ENT_DEC] ? pcirs_pkg::EDB_BYTE : rdWord[7:0]; // [RULE_04]
			rxK_ff <= rdWord[pcirs_pkg::ENT_DEC] | rdWord[pcirs_pkg::ENT_K];
			rxValid_ff <= 1'b1;
			status_ff <= pickStatus(rdWord, 1'b0); // [RULE_02]
		end else begin
			rxValid_ff <= 1'b0;
			status_ff <= pcirs_pkg::ST_OK; // [RULE_13]
		end
	end
	assign rxData = rxData_ff;
	assign rxK = rxK_ff;
	assign rxValid = rxValid_ff;
	assign rx_status_code = status_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_detect_code: assert property (detState_ff == pcirs_pkg::DET_DONE |-> status_ff == ($past(farPresent_ff) ? pcirs_pkg::ST_RX_DET : pcirs_pkg::ST_OK)) // [RULE_01]
		else $error("detect result code wrong");
	chk_error_slot: assert property (status_ff[2] |-> rxValid_ff && $past(primed_ff)) // [RULE_02]
		else $error("error code outside a byte slot");
	chk_decode_first: assert property (detState_ff == pcirs_pkg::DET_IDLE && rdEn && rdWord[pcirs_pkg::ENT_DEC] |=> status_ff == pcirs_pkg::ST_DEC_ERR) // [RULE_03]
		else $error("decode error lost priority");
	chk_decode_edb: assert property (status_ff == pcirs_pkg::ST_DEC_ERR |-> rxData_ff == pcirs_pkg::EDB_BYTE && rxK_ff) // [RULE_04]
		else $error("decode error without EDB");
	chk_disp_pass: assert property (status_ff == pcirs_pkg::ST_DISP_ERR |-> rxData_ff == $past(rdWord[7:0]) && $past(rdWord[pcirs_pkg::ENT_DISP])) // [RULE_05]
		else $error("disparity byte altered");
	chk_underflow_edb: assert property (status_ff == pcirs_pkg::ST_UDF |-> rxData_ff == pcirs_pkg::EDB_BYTE && $past(ebEmpty)) // [RULE_06]
		else $error("underflow without EDB");
	chk_overflow_slot: assert property (drop |=> pendOvf_ff) // [RULE_07]
		else $error("dropped symbol not recorded");
	chk_invert_latency: assert property (rx_invert_request [*4] |-> invActive_ff) // [RULE_08]
		else $error("inversion too late");
	chk_txneg_align: assert property (txForceNeg |-> $past(tx_force_negative_disparity, 2) && txDataOut == $past(txDataIn, 2)) // [RULE_09]
		else $error("disparity pulse misaligned");
	chk_skp_com: assert property (status_ff == pcirs_pkg::ST_SKP_ADD |-> $past(rdWord[pcirs_pkg::ENT_ADD]) && rxValid_ff) // [RULE_10]
		else $error("skp added shown off its symbol");
	chk_ok_idle: assert property (!primed_ff && detState_ff == pcirs_pkg::DET_IDLE |=> status_ff == pcirs_pkg::ST_OK) // [RULE_13]
		else $error("status not ok when idle");

	cov_underflow: cover property (status_ff == pcirs_pkg::ST_UDF);
	cov_overflow: cover property (status_ff == pcirs_pkg::ST_OVF);
	cov_detect: cover property (detState_ff == pcirs_pkg::DET_SHOW ##1 phyStatus);
	cov_decode: cover property (status_ff == pcirs_pkg::ST_DEC_ERR);
endmodule : pcirs_status_top

// ---- testbench/pcirs_mac_model.sv ----
// mac-side partner model: transmit bytes, inversion pin and detect handshake
`timescale 1ns/100ps
module pcirs_mac_model (
	// clock
	input wire logic clk,
	// from the phy
	input wire logic phyStatus,
	input wire logic [2:0] rx_status_code,
	// to the phy
	output logic rx_invert_request,
	output logic rx_detect_or_loopback_request,
	output logic tx_force_negative_disparity,
	output logic [7:0] txDataIn,
	output logic txKIn
);
	// ----------------------------------------------------------------
	// idle levels
	// ----------------------------------------------------------------
	initial begin
		rx_invert_request = 1'b0;
		rx_detect_or_loopback_request = 1'b0;
		tx_force_negative_disparity = 1'b0;
		txDataIn = 8'h00;
		txKIn = 1'b0;
	end

	// one byte; the force pulse never lasts beyond its own byte
	task send_tx(input logic [7:0] d, input logic neg);
		@(posedge clk);
		txDataIn <= d;
		txKIn <= d[7];
		tx_force_negative_disparity <= neg;
		@(posedge clk);
		tx_force_negative_disparity <= 1'b0;
		txDataIn <= ~d;
		txKIn <= ~d[7];
	endtask : send_tx

	// level pin, changed just after an edge
	task set_invert(input logic v);
		@(posedge clk);
		rx_invert_request <= v;
	endtask : set_invert

	// request, sample status on the first edge with phyStatus high, hold a while, release
	task detect(input int hold, output logic [2:0] seen, output logic ok);
		int n;
		n = 0;
		@(posedge clk);
		rx_detect_or_loopback_request <= 1'b1;
		while (phyStatus !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		seen = rx_status_code;
		repeat (hold) @(posedge clk);
		rx_detect_or_loopback_request <= 1'b0;
		while (phyStatus !== 1'b0 && n < 60) begin
			@(posedge clk);
			n++;
		end
		ok = n < 40;
	endtask : detect
endmodule : pcirs_mac_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the receive status reporting block
`timescale 1ns/100ps
module tb_top;
	logic clk, rst_n, rxInv, rxDet, txNeg, txKIn, txKOut, txForceNeg;
	logic [7:0] txDataIn, txDataOut, symData, rxData;
	logic [9:0] rawSymIn, rawSymOut;
	logic rxInvertActive, symValid, symK, symDecErr, symDispErr;
	logic symSkpAdded, symSkpRemoved, detDone, farEndPresent;
	logic rxK, rxValid, phyStatus;
	logic [2:0] rx_status_code;
	logic [11:0] slots [$];
	int failures = 0;
	int checked = 0;
	// {decode, disparity, skp add, skp rem, k, data}
	localparam logic [12:0] TBL [8] = '{13'h0011, 13'h1022, 13'h0833, 13'h1844,
		13'h0555, 13'h03bc, 13'h0c77, 13'h0188};

	// ----------------------------------------------------------------
	// design and partner
	// ----------------------------------------------------------------
	pcirs_status_top #(.EB_DEPTH(pcirs_pkg::EB_DEPTH_DEF)) i_pcirs_status_top (.clk(clk), .rst_n(rst_n),
		.rx_invert_request(rxInv), .rx_detect_or_loopback_request(rxDet),
		.tx_force_negative_disparity(txNeg), .txDataIn(txDataIn), .txKIn(txKIn),
		.txDataOut(txDataOut), .txKOut(txKOut), .txForceNeg(txForceNeg),
		.rawSymIn(rawSymIn), .rawSymOut(rawSymOut), .rxInvertActive(rxInvertActive),
		.symValid(symValid), .symData(symData), .symK(symK), .symDecErr(symDecErr),
		.symDispErr(symDispErr), .symSkpAdded(symSkpAdded), .symSkpRemoved(symSkpRemoved),
		.detDone(detDone), .farEndPresent(farEndPresent), .rxData(rxData), .rxK(rxK),
		.rxValid(rxValid), .rx_status_code(rx_status_code), .phyStatus(phyStatus));
	pcirs_mac_model i_pcirs_mac_model (.clk(clk), .phyStatus(phyStatus),
		.rx_status_code(rx_status_code), .rx_invert_request(rxInv),
		.rx_detect_or_loopback_request(rxDet), .tx_force_negative_disparity(txNeg),
		.txDataIn(txDataIn), .txKIn(txKIn));

	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// every presented slot, sampled before the edge updates it
	always @(posedge clk) begin
		if (rxValid === 1'b1)
			slots.push_back({rxK, rxData, rx_status_code});
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task stop_test;
		if (failures == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task check(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// a wait that ran out ends the run as a failure
	task bound(input int n, input int lim);
		if (n >= lim) begin
			failures++;
			stop_test();
		end
	endtask : bound

	// the bench's own reading of the slot priority
	function automatic logic [11:0] exp_slot(input logic [12:0] e);
		if (e[12])
			return {1'b1, pcirs_pkg::EDB_BYTE, pcirs_pkg::ST_DEC_ERR};
		if (e[11])
			return {e[8:0], pcirs_pkg::ST_DISP_ERR};
		if (e[10])
			return {e[8:0], pcirs_pkg::ST_SKP_ADD};
		if (e[9])
			return {e[8:0], pcirs_pkg::ST_SKP_REM};
		return {e[8:0], pcirs_pkg::ST_OK};
	endfunction : exp_slot

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_tx(input logic [7:0] d, input logic neg);
		int n;
		n = 0;
		i_pcirs_mac_model.send_tx(d, neg);
		while (txDataOut !== d && n < 6) begin
			@(posedge clk);
			n++;
		end
		bound(n, 6);
		check({2'h0, txKOut, txForceNeg, txDataOut}, {2'h0, d[7], neg, d});
		@(posedge clk);
		check({11'h000, txForceNeg}, 12'h000);
	endtask : t_tx

	task t_invert(input logic v, input logic [9:0] exp);
		int n;
		n = 0;
		i_pcirs_mac_model.set_invert(v);
		while (rxInvertActive !== v && n < 20) begin
			@(posedge clk);
			n++;
		end
		bound(n, 20);
		repeat (2) @(posedge clk);
		check({2'h0, rawSymOut}, {2'h0, exp});
	endtask : t_invert

	task t_detect(input logic far);
		logic [2:0] seen;
		logic ok;
		// a stray completion without a request must change nothing
		@(posedge clk);
		detDone <= 1'b1;
		@(posedge clk);
		detDone <= 1'b0;
		repeat (4) @(posedge clk);
		check({8'h00, phyStatus, rx_status_code}, 12'h000);
		fork
			i_pcirs_mac_model.detect(0, seen, ok);
			begin
				repeat (5) @(posedge clk);
				detDone <= 1'b1;
				farEndPresent <= far;
				@(posedge clk);
				detDone <= 1'b0;
				farEndPresent <= ~far;
			end
		join
		check({11'h000, ok}, 12'h001);
		check({9'h000, seen}, far ? 12'h003 : 12'h000);
	endtask : t_detect

	task t_stream;
		slots.delete();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{symDecErr, symDispErr, symSkpAdded, symSkpRemoved, symK, symData} <= TBL[i];
			symValid <= 1'b1;
		end
		@(posedge clk);
		symValid <= 1'b0;
		{symDecErr, symDispErr, symSkpAdded, symSkpRemoved, symK, symData} <= 13'h00ff;
		repeat (12) @(posedge clk);
		if (slots.size() < 9)
			bound(1, 1);
		for (int i = 0; i < 8; i++)
			check(slots[i], exp_slot(TBL[i]));
		check(slots[8], {1'b1, pcirs_pkg::EDB_BYTE, pcirs_pkg::ST_UDF});
	endtask : t_stream

	// reads held by a detect while depth plus one symbols arrive: the last is dropped
	task t_overflow;
		logic [2:0] seen;
		logic ok;
		int k;
		k = 0;
		slots.delete();
		fork
			i_pcirs_mac_model.detect(16, seen, ok);
			begin
				repeat (5) @(posedge clk);
				detDone <= 1'b1;
				farEndPresent <= 1'b0;
				@(posedge clk);
				detDone <= 1'b0;
				{symDecErr, symDispErr, symSkpAdded, symSkpRemoved, symK} <= 5'h00;
				for (int i = 0; i <= pcirs_pkg::EB_DEPTH_DEF; i++) begin
					symData <= 8'h40 + 8'(i);
					symValid <= 1'b1;
					@(posedge clk);
				end
				symValid <= 1'b0;
			end
		join
		// the next stored symbol carries the overflow mark
		repeat (12) @(posedge clk);
		symData <= 8'h5e;
		symValid <= 1'b1;
		@(posedge clk);
		symValid <= 1'b0;
		repeat (4) @(posedge clk);
		check({11'h000, ok}, 12'h001);
		check({9'h000, seen}, {9'h000, pcirs_pkg::ST_OK});
		foreach (slots[j]) begin
			if (slots[j] !== {1'b1, pcirs_pkg::EDB_BYTE, pcirs_pkg::ST_UDF}) begin
				if (k < pcirs_pkg::EB_DEPTH_DEF)
					check(slots[j], {1'b0, 8'h40 + 8'(k), pcirs_pkg::ST_OK});
				else
					check(slots[j], {1'b0, 8'h5e, pcirs_pkg::ST_OVF});
				k++;
			end
		end
		check(12'(k), 12'(pcirs_pkg::EB_DEPTH_DEF + 1));
	endtask : t_overflow

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		rawSymIn = 10'h2a5;
		{symValid, symK, symDecErr, symDispErr, symSkpAdded, symSkpRemoved} = 6'h00;
		symData = 8'h00;
		detDone = 1'b0;
		farEndPresent = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check({rxValid, phyStatus, txForceNeg, 6'h00, rx_status_code}, 12'h000);
		t_tx(8'h5a, 1'b1);
		t_tx(8'hc3, 1'b0);
		t_invert(1'b1, 10'h15a);
		t_invert(1'b0, 10'h2a5);
		t_detect(1'b1);
		t_detect(1'b0);
		t_stream();
		t_overflow();
		stop_test();
	end
endmodule : tb_top
